// ==== design/swr_pkg.sv ====
// Shared constants, types and helpers for the single-wire selection layer.
`default_nettype none

package swr_pkg;

  // Clock and counter sizing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 16;

  // Line times in nanoseconds, as the figures stand.
  localparam int RST_STD_NS = 120000;
  localparam int RST_FAST_NS = 16000;
  localparam int RST_LONG_NS = 480000;
  localparam int RST_KEEP_FAST_NS = 80000;
  localparam int PRES_DLY_STD_NS = 30000;
  localparam int PRES_DLY_FAST_NS = 3000;
  localparam int PRES_LOW_STD_NS = 80000;
  localparam int PRES_LOW_FAST_NS = 10000;
  localparam int SAMPLE_STD_NS = 30000;
  localparam int SAMPLE_FAST_NS = 3000;
  localparam int HOLD0_STD_NS = 30000;
  localparam int HOLD0_FAST_NS = 3000;

  // Cycle counts; least times round up to whole cycles.
  localparam int RST_STD_CYC_DEF = (RST_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LONG_CYC_DEF = (RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_KEEP_FAST_CYC_DEF = RST_KEEP_FAST_NS / CLK_PERIOD_NS;
  localparam int PRES_LOW_STD_CYC_DEF = (PRES_LOW_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] RST_FAST_CYC = CNT_W'((RST_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PRES_DLY_STD_CYC = CNT_W'((PRES_DLY_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PRES_DLY_FAST_CYC = CNT_W'((PRES_DLY_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PRES_LOW_FAST_CYC = CNT_W'((PRES_LOW_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SAMPLE_STD_CYC = CNT_W'((SAMPLE_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SAMPLE_FAST_CYC = CNT_W'((SAMPLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD0_STD_CYC = CNT_W'((HOLD0_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD0_FAST_CYC = CNT_W'((HOLD0_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Selection command codes.
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_COND_SEARCH = 8'hEC;
  localparam logic [7:0] CMD_SKIP = 8'hCC;
  localparam logic [7:0] CMD_RESUME = 8'hA5;
  localparam logic [7:0] CMD_FAST_SKIP = 8'h3C;
  localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

  // Identity defaults; these values are arbitrary.
  localparam logic [7:0] FAMILY_DEF = 8'h5A;
  localparam logic [39:0] SERIAL_DEF = 40'h00000C0DE1;
  localparam logic LOC_BIT7 = 1'b1;
  localparam logic [6:0] LOC_ALL_ONES = 7'h7F;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

  // Register byte offsets and reset values.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FUNC = 4'h8;
  localparam logic [3:0] REG_IDENT = 4'hC;
  localparam int FUNC_VALID_BIT = 8;
  localparam logic CTRL_RESET = 1'b0;

  // Transaction phases.
  typedef enum logic [3:0] {
    P_IDLE = 4'h0,
    P_RESET = 4'h1,
    P_PRES_WAIT = 4'h2,
    P_PRES_LOW = 4'h3,
    P_PRES_REL = 4'h4,
    P_ROM_CMD = 4'h5,
    P_READ_ID = 4'h6,
    P_MATCH = 4'h7,
    P_SRCH = 4'h8,
    P_FUNC = 4'h9,
    P_DONE = 4'hA
  } swr_phase_t;

  // Check byte over 56 identity bits, least significant bit first.
  function automatic logic [7:0] swr_crc8(input logic [55:0] data);
    logic [7:0] crc;
    logic fb;
    crc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = crc[0] ^ data[i];
      crc = crc >> 1;
      if (fb) begin
        crc = crc ^ CRC_POLY_REFL;
      end
    end
    return crc;
  endfunction

endpackage

`default_nettype wire

// ==== design/swr_low_timer.sv ====
// Saturating cycle counter used to time line lows and presence intervals.
`default_nettype none

module swr_low_timer import swr_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Control.
  input wire logic clear,
  input wire logic run,
  // Elapsed cycles.
  output logic [CNT_W-1:0] count
);

  // Saturation keeps a stuck-low line from wrapping back into a short slot.
  always_ff @(posedge ref_clk) begin
    if (reset || clear) begin
      count <= '0;
    end else if (run && (count != {CNT_W{1'b1}})) begin
      count <= count + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== design/swr_rom_layer.sv ====
// Device-side selection layer of a single-wire open-drain bus, with an Avalon-MM register slave.
//
// Behaviour
// R1 - Init, selection, function command, then data.
// R2 - Reset pulse answered by a presence pulse.
// R3 - Eight selection commands, each an 8-bit code.
// R4 - 33h shifts out family, serial, location, check.
// R5 - Location bits 0..6 follow live location inputs.
// R6 - Check byte fixed, location taken as ones.
// R7 - 55h compares 64 bits; mismatch idles.
// R8 - F0h sends bit, complement, reads master bit.
// R9 - ECh searches only with conditional request active.
// R10 - Completed search selects like a match.
// R11 - CCh goes straight to function command.
// R12 - A5h proceeds only with resume flag set.
// R13 - Resume flag set by match, search, fast-match.
// R14 - Resume flag cleared when another device selected.
// R15 - 3Ch sets fast speed, enters function phase.
// R16 - 69h matches at fast speed, sets fast.
// R17 - Unselected fast device keeps fast speed.
// R18 - Standard speed at power-up; fast times everything.
// R19 - Short reset keeps fast; long returns standard.
// R20 - After reset rise: delay, then presence low.
// R21 - Master samples presence at its sampling instant.
// R22 - Ready for slots right after presence recovery.
// R23 - Long low is a reset, speed dependent.
// R24 - Read zero pulls low for timed period.
// R25 - Check byte is x^8+x^5+x^4+1 over 56 bits.
// R26 - Unknown command or reset abandons the transaction.
// R27 - Identity bits move least significant first.
`default_nettype none

module swr_rom_layer import swr_pkg::*; #(
  parameter int RST_STD_CYC = RST_STD_CYC_DEF,
  parameter int RST_LONG_CYC = RST_LONG_CYC_DEF,
  parameter int PRES_LOW_STD_CYC = PRES_LOW_STD_CYC_DEF,
  parameter logic [7:0] FAMILY = FAMILY_DEF,
  parameter logic [39:0] SERIAL = SERIAL_DEF
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Open-drain bus line.
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  // Location straps, bit 0 is location_input_lsb and bit 6 location_input_msb.
  input wire logic [6:0] locationIn
);

  // Check byte is a constant computed with all location bits high.
  localparam logic [7:0] ID_CRC = swr_crc8({LOC_BIT7, LOC_ALL_ONES, SERIAL, FAMILY}); // R6 R25

  logic lineMeta_q, lineSync_q, linePrev_q;
  logic [6:0] locMeta_q, locSync_q;
  logic [CNT_W-1:0] lowCnt, presCnt;
  swr_phase_t phase_q;
  logic [5:0] bitIdx_q;
  logic [1:0] trip_q;
  logic [7:0] shift_q;
  logic sampled_q, driveQ, fastMatch_q;
  logic resume_flag_q, fast_speed_flag_q, fastPrev_q;
  logic conditional_search_request_q;
  logic [7:0] funcCmd_q, romCmd_q;
  logic funcValid_q, ackQ;
  logic fallEdge, riseEdge, slotEnd, resetSeen, resetRise, presStart, presEnd, presClr;
  logic [63:0] idWord;
  logic idBit, txBit, txActive;
  logic [7:0] rxByte;
  logic cmdDone, funcDone, matchFail, matchDone, srchFail, srchDone, condSkip;
  logic [CNT_W-1:0] rstCyc, sampleCyc, hold0Cyc, presDlyCyc, presLowCyc;
  logic [31:0] readMux;
  logic busWr;

  // Line and straps come from outside the clock domain, so two flops come first.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lineMeta_q <= 1'b1;
      lineSync_q <= 1'b1;
      linePrev_q <= 1'b1;
      locMeta_q <= 7'h7F;
      locSync_q <= 7'h7F;
    end else begin
      lineMeta_q <= lineIn;
      lineSync_q <= lineMeta_q;
      linePrev_q <= lineSync_q;
      locMeta_q <= locationIn;
      locSync_q <= locMeta_q;
    end
  end

  assign fallEdge = linePrev_q & ~lineSync_q;
  assign riseEdge = ~linePrev_q & lineSync_q;

  // Every window shortens in fast speed, reset and presence included.
  assign rstCyc = fast_speed_flag_q ? RST_FAST_CYC : CNT_W'(RST_STD_CYC); // R18 R23
  assign sampleCyc = fast_speed_flag_q ? SAMPLE_FAST_CYC : SAMPLE_STD_CYC;
  assign hold0Cyc = fast_speed_flag_q ? HOLD0_FAST_CYC : HOLD0_STD_CYC;
  assign presDlyCyc = fast_speed_flag_q ? PRES_DLY_FAST_CYC : PRES_DLY_STD_CYC;
  assign presLowCyc = fast_speed_flag_q ? PRES_LOW_FAST_CYC : CNT_W'(PRES_LOW_STD_CYC);

  // Low time measured from each master falling edge.
  swr_low_timer lowTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(fallEdge),
    .run(~lineSync_q),
    .count(lowCnt)
  );

  // Presence delay and duration share a second counter.
  swr_low_timer presTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(presClr),
    .run(1'b1),
    .count(presCnt)
  );

  // Identity, least significant field first; location bits are live.
  assign idWord = {ID_CRC, LOC_BIT7, locSync_q, SERIAL, FAMILY}; // R4 R5
  assign idBit = idWord[bitIdx_q]; // R27
  assign rxByte = {sampled_q, shift_q[7:1]};

  // Slot bits are acted on at the rising edge, so a reset pulse is never mistaken for a data zero.
  assign slotEnd = riseEdge && (lowCnt < rstCyc);
  assign resetSeen = ~lineSync_q && (lowCnt == rstCyc) && (phase_q != P_RESET) &&
                     (phase_q != P_PRES_WAIT) && (phase_q != P_PRES_LOW) && (phase_q != P_PRES_REL); // R23
  assign resetRise = riseEdge && (phase_q == P_RESET);
  assign presStart = (phase_q == P_PRES_WAIT) && (presCnt >= presDlyCyc);
  assign presEnd = (phase_q == P_PRES_LOW) && (presCnt >= presLowCyc);
  assign presClr = resetRise || presStart;

  // Events of the command, match and search sequences.
  assign cmdDone = slotEnd && (phase_q == P_ROM_CMD) && (bitIdx_q == 6'h07); // R3
  assign funcDone = slotEnd && (phase_q == P_FUNC) && (bitIdx_q == 6'h07);
  assign matchFail = slotEnd && (phase_q == P_MATCH) && (sampled_q != idBit);
  assign matchDone = slotEnd && (phase_q == P_MATCH) && (sampled_q == idBit) && (bitIdx_q == 6'h3F);
  assign srchFail = slotEnd && (phase_q == P_SRCH) && (trip_q == 2'h2) && (sampled_q != idBit);
  assign srchDone = slotEnd && (phase_q == P_SRCH) && (trip_q == 2'h2) && (sampled_q == idBit) &&
                    (bitIdx_q == 6'h3F);
  assign condSkip = cmdDone && (rxByte == CMD_COND_SEARCH) && !conditional_search_request_q;

  // Bit to send: identity bit, or its complement in the second search slot.
  always_comb begin
    txActive = 1'b0;
    txBit = 1'b1;
    case (phase_q)
      P_READ_ID: begin
        txActive = 1'b1;
        txBit = idBit; // R4
      end
      P_SRCH: begin
        txActive = (trip_q != 2'h2);
        txBit = (trip_q == 2'h0) ? idBit : ~idBit; // R8
      end
      default: begin
        txActive = 1'b0;
        txBit = 1'b1;
      end
    endcase
  end

  // Master bit is a zero if the line is still low at the sample point.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sampled_q <= 1'b1;
    end else if (fallEdge) begin
      sampled_q <= 1'b1;
    end else if (~lineSync_q && (lowCnt == sampleCyc)) begin
      sampled_q <= 1'b0;
    end
  end

  // Pull-down for presence and for read zeros; only a zero is ever driven.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      driveQ <= 1'b0;
    end else if (presStart) begin
      driveQ <= 1'b1; // R20
    end else if (presEnd || resetSeen) begin
      driveQ <= 1'b0;
    end else if (fallEdge && txActive && !txBit) begin
      driveQ <= 1'b1; // R24
    end else if (driveQ && (phase_q != P_PRES_LOW) && (lowCnt >= hold0Cyc)) begin
      driveQ <= 1'b0; // R24
    end
  end

  assign lineOut = 1'b0;
  assign lineOe = driveQ;

  // Transaction sequencer; a reset pulse outside the reset and presence phases wins over everything.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_q <= P_IDLE;
      bitIdx_q <= 6'h00;
      trip_q <= 2'h0;
      shift_q <= 8'h00;
      fastMatch_q <= 1'b0;
    end else if (resetSeen) begin
      phase_q <= P_RESET; // R26
    end else begin
      case (phase_q)
        P_RESET: begin
          if (resetRise) begin
            phase_q <= P_PRES_WAIT; // R2
          end
        end
        P_PRES_WAIT: begin
          if (presStart) begin
            phase_q <= P_PRES_LOW; // R20
          end
        end
        P_PRES_LOW: begin
          if (presEnd) begin
            phase_q <= P_PRES_REL;
          end
        end
        P_PRES_REL: begin
          if (lineSync_q) begin
            phase_q <= P_ROM_CMD; // R22
            bitIdx_q <= 6'h00;
            fastMatch_q <= 1'b0;
          end
        end
        P_ROM_CMD: begin
          if (slotEnd) begin
            shift_q <= rxByte;
            bitIdx_q <= bitIdx_q + 6'h01;
          end
          if (cmdDone) begin
            bitIdx_q <= 6'h00;
            trip_q <= 2'h0;
            // Decode the selection command.
            if (rxByte == CMD_READ_ID) begin
              phase_q <= P_READ_ID; // R4
            end else if (rxByte == CMD_MATCH) begin
              phase_q <= P_MATCH; // R7
            end else if (rxByte == CMD_FAST_MATCH) begin
              phase_q <= P_MATCH; // R16
              fastMatch_q <= 1'b1;
            end else if (rxByte == CMD_SEARCH) begin
              phase_q <= P_SRCH; // R8
            end else if (rxByte == CMD_COND_SEARCH) begin
              phase_q <= conditional_search_request_q ? P_SRCH : P_IDLE; // R9
            end else if ((rxByte == CMD_SKIP) || (rxByte == CMD_FAST_SKIP)) begin
              phase_q <= P_FUNC; // R11 R15
            end else if (rxByte == CMD_RESUME) begin
              phase_q <= resume_flag_q ? P_FUNC : P_IDLE; // R12
            end else begin
              phase_q <= P_IDLE; // R26
            end
          end
        end
        P_READ_ID: begin
          if (slotEnd) begin
            bitIdx_q <= bitIdx_q + 6'h01;
            if (bitIdx_q == 6'h3F) begin
              phase_q <= P_FUNC; // R1
            end
          end
        end
        P_MATCH: begin
          if (matchFail) begin
            phase_q <= P_IDLE; // R7
          end else if (slotEnd) begin
            bitIdx_q <= bitIdx_q + 6'h01;
            if (matchDone) begin
              phase_q <= P_FUNC;
            end
          end
        end
        P_SRCH: begin
          if (srchFail) begin
            phase_q <= P_IDLE; // R8
          end else if (slotEnd) begin
            trip_q <= (trip_q == 2'h2) ? 2'h0 : trip_q + 2'h1;
            if (trip_q == 2'h2) begin
              bitIdx_q <= bitIdx_q + 6'h01;
            end
            if (srchDone) begin
              phase_q <= P_FUNC; // R10
            end
          end
        end
        P_FUNC: begin
          if (slotEnd) begin
            shift_q <= rxByte;
            bitIdx_q <= bitIdx_q + 6'h01;
          end
          if (funcDone) begin
            phase_q <= P_DONE; // R1
          end
        end
        default: begin
          phase_q <= phase_q;
        end
      endcase
    end
  end

  // Resume flag: the set wins if both fire, which cannot happen in one slot anyway.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resume_flag_q <= 1'b0;
    end else if (matchDone || srchDone) begin
      resume_flag_q <= 1'b1; // R13
    end else if (matchFail || srchFail || condSkip) begin
      resume_flag_q <= 1'b0; // R14
    end
  end

  // Fast speed flag; a speed between the two reset limits is left as it was.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fast_speed_flag_q <= 1'b0; // R18
      fastPrev_q <= 1'b0;
    end else if (resetRise && (lowCnt >= CNT_W'(RST_LONG_CYC))) begin
      fast_speed_flag_q <= 1'b0; // R19
    end else if (cmdDone && ((rxByte == CMD_FAST_SKIP) || (rxByte == CMD_FAST_MATCH))) begin
      fastPrev_q <= fast_speed_flag_q;
      fast_speed_flag_q <= 1'b1; // R15 R16
    end else if (matchFail && fastMatch_q) begin
      fast_speed_flag_q <= fastPrev_q; // R17
    end
  end

  // Last selection and function bytes; the valid bit's set wins over a clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      romCmd_q <= 8'h00;
      funcCmd_q <= 8'h00;
      funcValid_q <= 1'b0;
    end else begin
      if (cmdDone) begin
        romCmd_q <= rxByte;
      end
      if (funcDone) begin
        funcCmd_q <= rxByte;
        funcValid_q <= 1'b1;
      end else if (busWr && (avs_address == REG_FUNC) && avs_writedata[FUNC_VALID_BIT]) begin
        funcValid_q <= 1'b0;
      end
    end
  end

  // Bus slave answers every access after exactly one wait cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avs_read || avs_write) && !ackQ;
    end
  end

  assign avs_waitrequest = !ackQ;
  assign busWr = avs_write && ackQ;

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    readMux = 32'h00000000;
    if (avs_address == REG_CTRL) begin
      readMux = {31'h00000000, conditional_search_request_q};
    end else if (avs_address == REG_STATUS) begin
      readMux = {24'h000000, phase_q, 1'b0, (phase_q == P_FUNC) || (phase_q == P_DONE),
                 fast_speed_flag_q, resume_flag_q};
    end else if (avs_address == REG_FUNC) begin
      readMux = {15'h0000, romCmd_q, funcValid_q, funcCmd_q};
    end else if (avs_address == REG_IDENT) begin
      readMux = {16'h0000, ID_CRC, idWord[55:48]};
    end
  end

  // Read data is latched in the wait cycle and stands through the answer cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ackQ) begin
      avs_readdata <= readMux;
    end
  end

  // Software-held conditional search request.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conditional_search_request_q <= CTRL_RESET;
    end else if (busWr && (avs_address == REG_CTRL)) begin
      conditional_search_request_q <= avs_writedata[0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_read_id;
    cmdDone && (rxByte == CMD_READ_ID) |=> (phase_q == P_READ_ID) && (bitIdx_q == 6'h00);
  endproperty
  a_read_id: assert property (p_read_id) else $error("read id not entered"); // R4

  property p_match_fail;
    matchFail |=> (phase_q == P_IDLE) && !resume_flag_q;
  endproperty
  a_match_fail: assert property (p_match_fail) else $error("mismatch did not idle"); // R7

  property p_cond_skip;
    cmdDone && (rxByte == CMD_COND_SEARCH) && !conditional_search_request_q |=> phase_q == P_IDLE;
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("cond search without request"); // R9

  property p_resume_clear;
    cmdDone && (rxByte == CMD_RESUME) && !resume_flag_q |=> phase_q == P_IDLE;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("resume without flag"); // R12

  property p_select_sets_resume;
    matchDone || srchDone |=> resume_flag_q && (phase_q == P_FUNC);
  endproperty
  a_select_sets_resume: assert property (p_select_sets_resume) else $error("resume not set"); // R13

  property p_fast_skip;
    cmdDone && (rxByte == CMD_FAST_SKIP) |=> fast_speed_flag_q && (phase_q == P_FUNC);
  endproperty
  a_fast_skip: assert property (p_fast_skip) else $error("fast skip failed"); // R15

  property p_fast_kept;
    matchFail && fastMatch_q && fastPrev_q |=> fast_speed_flag_q;
  endproperty
  a_fast_kept: assert property (p_fast_kept) else $error("fast speed lost"); // R17

  property p_long_reset;
    resetRise && (lowCnt >= CNT_W'(RST_LONG_CYC)) |=> !fast_speed_flag_q ##1 (phase_q == P_PRES_WAIT);
  endproperty
  a_long_reset: assert property (p_long_reset) else $error("long reset kept fast"); // R19

  property p_presence;
    presStart |=> lineOe [*8];
  endproperty
  a_presence: assert property (p_presence) else $error("presence pulse too short"); // R20

  property p_reset_seen;
    resetSeen |=> (phase_q == P_RESET) && !lineOe;
  endproperty
  a_reset_seen: assert property (p_reset_seen) else $error("long low not a reset"); // R23

  property p_read_zero;
    fallEdge && txActive && !txBit |=> lineOe [*8];
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read zero not driven"); // R24

  property p_read_one;
    fallEdge && txActive && txBit && !driveQ |=> !lineOe;
  endproperty
  a_read_one: assert property (p_read_one) else $error("read one drove line"); // R24

  c_presence: cover property (presEnd);
  c_search_done: cover property (srchDone);
  c_func_cmd: cover property (funcDone);

endmodule

`default_nettype wire

// ==== verification/swr_bus_master.sv ====
// Behavioural bus master that makes every slot and reset falling edge on the single-wire line.
`default_nettype none

module swr_bus_master (
  // Clock.
  input wire logic ref_clk,
  // Device pull-down and resolved line level.
  input wire logic lineOe,
  output logic lineLvl,
  // Waits that ran out of their bound.
  output int lostCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pull = 1'b0;
  // The pull-up wins only while nobody pulls low.
  assign lineLvl = !(pull || lineOe);
  initial lostCnt = 0;
  // One low pulse, a sample, then a wait for the rise plus recovery.
  task automatic slot(input int lowCyc, input int smp, output logic bitV);
    int n;
    pull <= 1'b1;
    repeat (lowCyc) @(posedge ref_clk);
    pull <= 1'b0;
    repeat (smp) @(posedge ref_clk);
    bitV = lineLvl;
    n = 0;
    while (lineLvl !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) lostCnt++;
    // Recovery keeps the next fall clear of the device's slot timer.
    repeat (10) @(posedge ref_clk);
  endtask
  // Sends n bits least significant first; a one is a tenth of a zero.
  task automatic wr(input logic [63:0] v, input int n, input int lo0);
    logic x;
    for (int i = 0; i < n; i++) begin
      slot(v[i] ? lo0 / 10 : lo0, 0, x);
    end
  endtask
  // Read slots with a short fall, sampled well inside the device's hold.
  task automatic rd(input int n, output logic [63:0] v);
    logic x;
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      slot(8, 60, x);
      v[i] = x;
    end
  endtask
endmodule

`default_nettype wire

// ==== verification/test_swr_rom_layer.sv ====
// Self-checking bench for the single-wire selection layer.
`default_nettype none

module test_swr_rom_layer import swr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, lineLvl, lineOut, lineOe, b, fb;
  logic [6:0] locationIn = 7'h35;
  logic [63:0] id, r;
  logic [7:0] c;
  int mismatches = 0;
  int checks_done = 0;
  int lostCnt;
  always #5 ref_clk = ~ref_clk;
  swr_rom_layer #(.RST_STD_CYC(4000), .RST_LONG_CYC(8000), .PRES_LOW_STD_CYC(200)) swr_rom_layer_inst (
    .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lineIn(lineLvl), .lineOut(lineOut), .lineOe(lineOe), .locationIn(locationIn));
  swr_bus_master swr_bus_master_inst (.ref_clk(ref_clk), .lineOe(lineOe), .lineLvl(lineLvl), .lostCnt(lostCnt));
  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    mismatches += lostCnt;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access held until waitrequest is sampled low.
  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      test_done();
    end else begin
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Status bits are selected, fast speed and resume, high to low.
  task automatic stat(input logic [2:0] e);
    av(REG_STATUS, 1'b0, 32'h0);
    chk("status", 64'(e), 64'(q[2:0]));
  endtask
  // Short reset at fast timing with its presence check.
  task automatic frst();
    swr_bus_master_inst.slot(1700, 800, b);
    chk("fast presence", 64'h0, 64'(b));
  endtask
  initial begin
    // The stored check byte treats every location bit as one.
    c = 8'h00;
    id = {8'h00, 1'b1, 7'h7F, SERIAL_DEF, FAMILY_DEF};
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ id[i];
      c = (c >> 1) ^ (fb ? 8'h8C : 8'h00);
    end
    id = {c, 1'b1, locationIn, SERIAL_DEF, FAMILY_DEF};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    av(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", 64'h0, 64'(q));
    av(REG_CTRL, 1'b1, 32'h1);
    av(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl rw", 64'h1, 64'(q));
    av(REG_CTRL, 1'b1, 32'h0);
    av(4'h1, 1'b0, 32'h0);
    chk("unmapped", 64'h0, 64'(q));
    stat(3'h0);
    swr_bus_master_inst.slot(4500, 3100, b);
    chk("presence", 64'h0, 64'(b));
    swr_bus_master_inst.wr(64'(CMD_FAST_SKIP), 8, 3200);
    stat(3'h6);
    frst();
    stat(3'h2);
    $display("Test init and speed done");
    swr_bus_master_inst.wr(64'(CMD_READ_ID), 8, 330);
    swr_bus_master_inst.rd(64, r);
    chk("identity", id, r);
    frst();
    swr_bus_master_inst.wr(64'(CMD_MATCH), 8, 330);
    swr_bus_master_inst.wr(id, 64, 330);
    stat(3'h7);
    frst();
    swr_bus_master_inst.wr(64'(CMD_RESUME), 8, 330);
    stat(3'h7);
    $display("Test identity and match done");
    frst();
    swr_bus_master_inst.wr(64'(CMD_SEARCH), 8, 330);
    swr_bus_master_inst.rd(2, r);
    chk("search pair", 64'({!id[0], id[0]}), 64'(r[1:0]));
    swr_bus_master_inst.wr(~id, 1, 330);
    stat(3'h2);
    frst();
    swr_bus_master_inst.wr(64'(CMD_RESUME), 8, 330);
    stat(3'h2);
    frst();
    swr_bus_master_inst.wr(64'(CMD_COND_SEARCH), 8, 330);
    stat(3'h2);
    frst();
    swr_bus_master_inst.wr(64'(CMD_FAST_MATCH), 8, 330);
    swr_bus_master_inst.wr(~id, 1, 330);
    stat(3'h2);
    frst();
    swr_bus_master_inst.wr(64'(CMD_SKIP), 8, 330);
    stat(3'h6);
    // With the request raised, the conditional search joins in like a plain search.
    av(REG_CTRL, 1'b1, 32'h1);
    frst();
    swr_bus_master_inst.wr(64'(CMD_COND_SEARCH), 8, 330);
    swr_bus_master_inst.rd(2, r);
    chk("cond search pair", 64'({!id[0], id[0]}), 64'(r[1:0]));
    stat(3'h2);
    $display("Test search and skip done");
    swr_bus_master_inst.slot(8100, 3100, b);
    chk("long presence", 64'h0, 64'(b));
    stat(3'h0);
    // New strap levels must show in the location byte while the check byte stays fixed.
    locationIn <= 7'h4A;
    repeat (3) @(posedge ref_clk);
    av(REG_IDENT, 1'b0, 32'h0);
    chk("live location", 64'({c, 1'b1, 7'h4A}), 64'(q));
    chk("line out", 64'h0, 64'(lineOut));
    $display("Test long reset done");
    test_done();
  end
endmodule

`default_nettype wire
